//--- hdl/timer_pulse_period_measure_consts.vh
// Constants for the pulse period measurement timer
`ifndef TIMER_PULSE_PERIOD_MEASURE_CONSTS_VH
`define TIMER_PULSE_PERIOD_MEASURE_CONSTS_VH

// Count source select codes
`define TPM_SRC_F1          2'h0
`define TPM_SRC_F2          2'h1
`define TPM_SRC_F8          2'h2
`define TPM_SRC_RING        2'h3

// Main clock divider: width, divide by two bit, divide by eight terminal count and reset value
`define TPM_DIV_W           3
`define TPM_DIV2_BIT        0
`define TPM_DIV8_LAST       3'h7
`define TPM_DIV_RESET       3'h0

// Mode register field positions
`define TPM_MODE_BIT0       0
`define TPM_MODE_BIT1       1
`define TPM_MODE_BIT2       2
`define TPM_POL_BIT         3
`define TPM_RUN_BIT         4
`define TPM_EDG_BIT         5
`define TPM_UND_BIT         6
`define TPM_SPARE_BIT       7

// Mode select code for pulse period measurement
`define TPM_MODE_PERIOD     3'h3

// Reset values
`define TPM_MODE_RESET      3'h0
`define TPM_POL_RESET       1'b0
`define TPM_RUN_RESET       1'b0
`define TPM_FLAG_RESET      1'b0
`define TPM_CNT_RESET_BIT   1'b1
`define TPM_BUF_RESET_BIT   1'b0

`endif

//--- hdl/pin_sync.v
// Two-stage synchroniser for a group of asynchronous input pins
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_n,
  input  wire             ce,
  // Asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      // First stage feeds only the second stage
      always @(posedge clock) begin
        if (!rst_n) begin
          stage1_q[i] <= 1'b0;
          stage2_q[i] <= 1'b0;
        end else if (ce) begin
          stage1_q[i] <= asyncIn[i];
          stage2_q[i] <= stage1_q[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_q;

endmodule // pin_sync

`default_nettype wire

//--- hdl/timer_pulse_period_measure.v
// Reloadable down-counter with prescaler, measuring an external pulse period
//
// Overview of operation
// - Count down; after active edge, latch timer into buffer at next prescaler underflow.
// - At second prescaler underflow after the edge, reload timer and keep counting.
// - Writing one to run bit starts counting, writing zero stops it.
// - Timer interrupt on every timer underflow and on every measurement reload.
// - Edge interrupt on the active edge that ends a measurement period.
// - In measurement mode timer read returns buffer contents; a read releases buffer for a new latch.
// - Writes while stopped load both reload register and counter.
// - Writes while running: reload at next input, counter at second, resume at third.
// - Polarity bit selects which edge delimits the measured period.
// - Pin select bit routes one of two input pins to the measured input.
// - Timer is stopped after reset; software loads values before starting.
// - Prescaler and timer read as separate bytes; count may move in between.
// - Edge and underflow flags clear on writing zero, stay on writing one.
// - Edge flag may set at the first prescaler underflow after start.
// - Run bit reads zero after start write until next count input, then one.
// - After stop write, counting stops at next count input; bit reads one till then.
`timescale 1ns/1ns
`default_nettype none
`include "timer_pulse_period_measure_consts.vh"

module timer_pulse_period_measure #(
  parameter WIDTH = 8
) (
  // Clock, reset and clock enable
  input  wire             clock,
  input  wire             rst_n,
  input  wire             ce,
  // External pins
  input  wire             measuredInputPinA,
  input  wire             measuredInputPinB,
  input  wire             ringOscClock,
  // Static configuration
  input  wire [1:0]       countSourceSelect,
  input  wire             inputPinSelect,
  // Register writes and reads
  input  wire             modeWrite,
  input  wire [7:0]       modeWriteData,
  input  wire             prescalerWrite,
  input  wire             timerWrite,
  input  wire [WIDTH-1:0] writeData,
  input  wire             timerRead,
  // Read data and events
  output reg  [7:0]       modeReadData_q,
  output reg  [WIDTH-1:0] prescalerReadData_q,
  output reg  [WIDTH-1:0] timerReadData_q,
  output reg              timerIrq_q,
  output reg              edgeIrq_q
);

  // One-hot states of the measurement sequence
  localparam [2:0] MEAS_IDLE   = 3'h1;
  localparam [2:0] MEAS_LATCH  = 3'h2;
  localparam [2:0] MEAS_RELOAD = 3'h4;

  // One-hot states of a write made while counting
  localparam [3:0] WR_IDLE   = 4'h1;
  localparam [3:0] WR_RELOAD = 4'h2;
  localparam [3:0] WR_LOAD   = 4'h4;
  localparam [3:0] WR_RESUME = 4'h8;

  localparam [WIDTH-1:0] CNT_ZERO = {WIDTH{1'b0}};
  localparam [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

  // Synchronised pins: bit 0 pin A, bit 1 pin B, bit 2 ring oscillator
  wire [2:0] pinSync;

  pin_sync #(
    .WIDTH (3)
  ) uPinSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .ce      (ce),
    .asyncIn ({ringOscClock, measuredInputPinB, measuredInputPinA}),
    .syncOut (pinSync)
  );

  // State
  reg [`TPM_DIV_W-1:0] divCnt_q;
  reg                  ringPrev_q;
  reg [2:0]            modeSel_q;
  reg                  polarity_q;
  reg                  runReq_q;
  reg                  runActive_q;
  reg                  edgeFlag_q;
  reg                  underflowFlag_q;
  reg [WIDTH-1:0]      prescReload_q;
  reg [WIDTH-1:0]      prescCnt_q;
  reg [WIDTH-1:0]      timerReload_q;
  reg [WIDTH-1:0]      timerCnt_q;
  reg [WIDTH-1:0]      readBuf_q;
  reg                  bufHeld_q;
  reg                  sample_q;
  reg [2:0]            measState_q;
  reg [3:0]            wrState_q;
  reg [WIDTH-1:0]      wrData_q;
  reg                  wrPresc_q;
  reg                  wrTimer_q;

  // Combinational terms
  reg         countTick;
  reg [2:0]   measState_d;
  reg [7:0]   modeRead;
  wire        measuredInput;
  wire        ringTick;
  wire        activeLevel;
  wire        measMode;
  wire        counting;
  wire        prescUnder;
  wire        timerZero;
  wire        activeEdge;
  wire        measLatch;
  wire        measReload;
  wire        timerUnder;
  wire        edgeClear;
  wire        underClear;
  wire        startTick;

  // Pin routing and polarity; only the synchronised copies are looked at
  assign measuredInput = inputPinSelect ? pinSync[1] : pinSync[0];
  assign activeLevel   = ~polarity_q;
  assign ringTick      = pinSync[2] & ~ringPrev_q;
  assign measMode      = (modeSel_q == `TPM_MODE_PERIOD);

  // Free-running main clock divider and ring oscillator edge history
  always @(posedge clock) begin
    if (!rst_n) begin
      divCnt_q   <= `TPM_DIV_RESET;
      ringPrev_q <= 1'b0;
    end else if (ce) begin
      divCnt_q   <= divCnt_q + 3'h1;
      ringPrev_q <= pinSync[2];
    end
  end

  // Count source selection; ring ticks are slower than the main clock
  always @* begin
    case (countSourceSelect)
      `TPM_SRC_F1:   countTick = 1'b1;
      `TPM_SRC_F2:   countTick = divCnt_q[`TPM_DIV2_BIT];
      `TPM_SRC_F8:   countTick = (divCnt_q == `TPM_DIV8_LAST);
      `TPM_SRC_RING: countTick = ringTick;
      default:       countTick = 1'b0;
    endcase
  end

  // Counting is paused while a running write moves data into the counters
  assign counting   = runActive_q & countTick &
                      ((wrState_q == WR_IDLE) | (wrState_q == WR_RESUME));
  assign prescUnder = counting & (prescCnt_q == CNT_ZERO);
  assign timerZero  = (timerCnt_q == CNT_ZERO);
  assign startTick  = countTick & runReq_q & ~runActive_q;

  // The input is only sampled at prescaler underflow, so narrow pulses can be lost
  assign activeEdge = measMode & prescUnder & (measuredInput == activeLevel) &
                      (sample_q != activeLevel);
  assign measLatch  = measMode & prescUnder & (measState_q == MEAS_LATCH);
  assign measReload = measMode & prescUnder & (measState_q == MEAS_RELOAD);
  assign timerUnder = prescUnder & timerZero & ~measReload;

  // Flag clears come from writing zero to the flag positions
  assign edgeClear  = modeWrite & ~modeWriteData[`TPM_EDG_BIT];
  assign underClear = modeWrite & ~modeWriteData[`TPM_UND_BIT];

  // Mode, polarity and run request; stopped after reset
  always @(posedge clock) begin
    if (!rst_n) begin
      modeSel_q  <= `TPM_MODE_RESET;
      polarity_q <= `TPM_POL_RESET;
      runReq_q   <= `TPM_RUN_RESET;
    end else if (ce && modeWrite) begin
      modeSel_q  <= {modeWriteData[`TPM_MODE_BIT2],
                     modeWriteData[`TPM_MODE_BIT1],
                     modeWriteData[`TPM_MODE_BIT0]};
      polarity_q <= modeWriteData[`TPM_POL_BIT];
      runReq_q   <= modeWriteData[`TPM_RUN_BIT];
    end
  end

  // Run status follows the request only at a count-source input
  always @(posedge clock) begin
    if (!rst_n) begin
      runActive_q <= `TPM_RUN_RESET;
    end else if (ce && countTick) begin
      runActive_q <= runReq_q;
    end
  end

  // Sticky flags; a hardware set in the same cycle as a clear wins
  always @(posedge clock) begin
    if (!rst_n) begin
      edgeFlag_q      <= `TPM_FLAG_RESET;
      underflowFlag_q <= `TPM_FLAG_RESET;
    end else if (ce) begin
      edgeFlag_q      <= (edgeFlag_q & ~edgeClear) | activeEdge;
      underflowFlag_q <= (underflowFlag_q & ~underClear) | timerUnder;
    end
  end

  // Input sample history; starting forces the inactive level so a level
  // already active at start is seen as an edge at the first underflow
  always @(posedge clock) begin
    if (!rst_n) begin
      sample_q <= 1'b0;
    end else if (ce) begin
      if (startTick) begin
        sample_q <= ~activeLevel;
      end else if (prescUnder) begin
        sample_q <= measuredInput;
      end
    end
  end

  // Measurement sequence: edge, latch at next underflow, reload at the one after
  always @* begin
    measState_d = measState_q;
    if (!measMode || !runActive_q) begin
      measState_d = MEAS_IDLE;
    end else if (activeEdge) begin
      measState_d = MEAS_LATCH;
    end else if (prescUnder) begin
      case (measState_q)
        MEAS_IDLE:   measState_d = MEAS_IDLE;
        MEAS_LATCH:  measState_d = MEAS_RELOAD;
        MEAS_RELOAD: measState_d = MEAS_IDLE;
        default:     measState_d = MEAS_IDLE;
      endcase
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      measState_q <= MEAS_IDLE;
    end else if (ce) begin
      measState_q <= measState_d;
    end
  end

  // Read-out buffer; a latch is taken only while the buffer is free, so one arriving while it is held is lost
  always @(posedge clock) begin
    if (!rst_n) begin
      readBuf_q <= {WIDTH{`TPM_BUF_RESET_BIT}};
      bufHeld_q <= 1'b0;
    end else if (ce) begin
      if (measLatch && !bufHeld_q) begin
        readBuf_q <= timerCnt_q;
        bufHeld_q <= 1'b1;
      end else if (timerRead) begin
        bufHeld_q <= 1'b0;
      end
    end
  end

  // Write sequencer for prescaler and timer writes made while counting
  always @(posedge clock) begin
    if (!rst_n) begin
      wrState_q <= WR_IDLE;
      wrData_q  <= {WIDTH{`TPM_BUF_RESET_BIT}};
      wrPresc_q <= 1'b0;
      wrTimer_q <= 1'b0;
    end else if (ce) begin
      if ((prescalerWrite || timerWrite) && runActive_q) begin
        wrState_q <= WR_RELOAD;
        wrData_q  <= writeData;
        wrPresc_q <= prescalerWrite;
        wrTimer_q <= timerWrite;
      end else if (!runActive_q) begin
        wrState_q <= WR_IDLE;
      end else if (countTick) begin
        case (wrState_q)
          WR_IDLE:   wrState_q <= WR_IDLE;
          WR_RELOAD: wrState_q <= WR_LOAD;
          WR_LOAD:   wrState_q <= WR_RESUME;
          WR_RESUME: wrState_q <= WR_IDLE;
          default:   wrState_q <= WR_IDLE;
        endcase
      end
    end
  end

  // Reload registers and counters
  always @(posedge clock) begin
    if (!rst_n) begin
      prescReload_q <= {WIDTH{`TPM_CNT_RESET_BIT}};
      prescCnt_q    <= {WIDTH{`TPM_CNT_RESET_BIT}};
      timerReload_q <= {WIDTH{`TPM_CNT_RESET_BIT}};
      timerCnt_q    <= {WIDTH{`TPM_CNT_RESET_BIT}};
    end else if (ce) begin
      if (!runActive_q) begin
        // Stopped: a write goes to reload register and counter at once
        if (prescalerWrite) begin
          prescReload_q <= writeData;
          prescCnt_q    <= writeData;
        end else if (wrState_q != WR_IDLE && wrPresc_q) begin
          prescReload_q <= wrData_q;
          prescCnt_q    <= wrData_q;
        end
        if (timerWrite) begin
          timerReload_q <= writeData;
          timerCnt_q    <= writeData;
        end else if (wrState_q != WR_IDLE && wrTimer_q) begin
          timerReload_q <= wrData_q;
          timerCnt_q    <= wrData_q;
        end
      end else if (countTick && wrState_q == WR_RELOAD) begin
        if (wrPresc_q) begin
          prescReload_q <= wrData_q;
        end
        if (wrTimer_q) begin
          timerReload_q <= wrData_q;
        end
      end else if (countTick && wrState_q == WR_LOAD) begin
        prescCnt_q <= prescReload_q;
        timerCnt_q <= timerReload_q;
      end else if (prescUnder) begin
        prescCnt_q <= prescReload_q;
        if (measReload || timerZero) begin
          timerCnt_q <= timerReload_q;
        end else begin
          timerCnt_q <= timerCnt_q - CNT_ONE;
        end
      end else if (counting) begin
        prescCnt_q <= prescCnt_q - CNT_ONE;
      end
    end
  end

  // Mode register read view: run bit shows the real counting state
  always @* begin
    modeRead                 = 8'h00;
    modeRead[`TPM_MODE_BIT0] = modeSel_q[0];
    modeRead[`TPM_MODE_BIT1] = modeSel_q[1];
    modeRead[`TPM_MODE_BIT2] = modeSel_q[2];
    modeRead[`TPM_POL_BIT]   = polarity_q;
    modeRead[`TPM_RUN_BIT]   = runActive_q;
    modeRead[`TPM_EDG_BIT]   = edgeFlag_q;
    modeRead[`TPM_UND_BIT]   = underflowFlag_q;
  end

  // Registered read data; each byte is sampled on its own, so a prescaler
  // and timer pair read on different cycles may not be coherent
  always @(posedge clock) begin
    if (!rst_n) begin
      modeReadData_q      <= 8'h00;
      prescalerReadData_q <= {WIDTH{`TPM_CNT_RESET_BIT}};
      timerReadData_q     <= {WIDTH{`TPM_CNT_RESET_BIT}};
    end else if (ce) begin
      modeReadData_q      <= modeRead;
      prescalerReadData_q <= prescCnt_q;
      timerReadData_q     <= measMode ? readBuf_q : timerCnt_q;
    end
  end

  // Interrupt request pulses
  always @(posedge clock) begin
    if (!rst_n) begin
      timerIrq_q <= 1'b0;
      edgeIrq_q  <= 1'b0;
    end else if (ce) begin
      timerIrq_q <= timerUnder | measReload;
      edgeIrq_q  <= activeEdge;
    end
  end

endmodule // timer_pulse_period_measure

`default_nettype wire

//--- bench/timer_pulse_period_measure_chk.sv
// Concurrent checks on the ports of the pulse period measurement timer
`timescale 1ns/1ns
`default_nettype none
module timer_pulse_period_measure_chk #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst_n,
  // Requests
  input wire logic             modeWrite,
  input wire logic [7:0]       modeWriteData,
  input wire logic             timerWrite,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [1:0]       countSourceSelect,
  // Read data and events
  input wire logic [7:0]       modeReadData_q,
  input wire logic [WIDTH-1:0] prescalerReadData_q,
  input wire logic [WIDTH-1:0] timerReadData_q,
  input wire logic             timerIrq_q,
  input wire logic             edgeIrq_q
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Run status as read back; it trails the real state by a cycle
  wire running = modeReadData_q[4];
  wire period  = modeReadData_q[2:0] == 3'h3;

  AST_RUN_START: assert property (
    modeWrite && modeWriteData[4] && !running && countSourceSelect != 2'h3
      |=> !running ##[1:12] running) else $error("run status did not follow start");
  AST_RUN_STOP: assert property (
    modeWrite && !modeWriteData[4] && running && countSourceSelect != 2'h3
      |=> running ##[1:12] !running) else $error("run status did not follow stop");
  AST_STOPPED_WRITE: assert property (
    timerWrite && !running && !period |-> ##2 timerReadData_q == $past(writeData, 2))
    else $error("stopped timer write not loaded");
  // Prescaler kept far from underflow so the loaded value is still visible
  AST_RUNNING_WRITE: assert property (
    timerWrite && running && !period && countSourceSelect == 2'h0
      && prescalerReadData_q > 8'h08 |-> ##4 timerReadData_q == $past(writeData, 4))
    else $error("running timer write not applied");
  AST_FLAG_CLEAR: assert property (
    modeWrite && modeWriteData[6:4] == 3'h0 && !running |-> ##2 modeReadData_q[6:5] == 2'h0)
    else $error("flags not cleared by zero");
  AST_UND_KEEP: assert property (
    modeWrite && modeWriteData[6] && modeReadData_q[6] && !$past(modeWrite)
      |-> ##2 modeReadData_q[6]) else $error("underflow flag lost on write of one");
  AST_EDGE_FLAG: assert property (
    edgeIrq_q |-> ##[0:2] modeReadData_q[5]) else $error("edge event without edge flag");
  AST_UND_FLAG: assert property (
    $rose(modeReadData_q[6]) |-> timerIrq_q || $past(timerIrq_q) || $past(timerIrq_q, 2))
    else $error("underflow flag rose without timer request");
  AST_QUIET: assert property (
    !running [*4] |-> !$past(timerIrq_q, 2) && !$past(edgeIrq_q, 2))
    else $error("request while stopped");

  // Main scenarios reached
  cover property (edgeIrq_q && period);
  cover property (timerIrq_q && !period);
  cover property (timerWrite && running);
endmodule // timer_pulse_period_measure_chk

bind timer_pulse_period_measure timer_pulse_period_measure_chk #(.WIDTH(WIDTH)) chk_i (
  .clock(clock), .rst_n(rst_n), .modeWrite(modeWrite), .modeWriteData(modeWriteData),
  .timerWrite(timerWrite), .writeData(writeData), .countSourceSelect(countSourceSelect),
  .modeReadData_q(modeReadData_q), .prescalerReadData_q(prescalerReadData_q),
  .timerReadData_q(timerReadData_q), .timerIrq_q(timerIrq_q), .edgeIrq_q(edgeIrq_q)
);
`default_nettype wire

//--- bench/pulse_source_model.sv
// External pulse source feeding the measured input
`timescale 1ns/1ns
`default_nettype none
module pulse_source_model (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        enable,
  // Waveform shape in clock cycles
  input  wire logic [15:0] periodCycles,
  input  wire logic [15:0] highCycles,
  // Pin
  output var  logic        pinLevel
);
  logic [15:0] phaseCnt;

  initial begin
    phaseCnt = 16'h0000;
    pinLevel = 1'b0;
  end

  // High then low each period; widths are set well over one prescaler period
  always @(posedge clock) begin
    phaseCnt <= (!enable || phaseCnt >= periodCycles - 16'h0001) ? 16'h0000 : phaseCnt + 16'h0001;
    // Edges land off the clock edge, as from a truly asynchronous source
    pinLevel <= #3 enable && (phaseCnt < highCycles);
  end
endmodule // pulse_source_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking testbench for the pulse period measurement timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clock, rst_n, ce, ringOscClock, inputPinSelect, srcEnable, pinLevel;
  logic        modeWrite, prescalerWrite, timerWrite, timerRead, timerIrq_q, edgeIrq_q;
  logic [1:0]  countSourceSelect;
  logic [7:0]  modeWriteData, writeData, modeReadData_q, prescalerReadData_q, timerReadData_q;
  logic [7:0]  p, t;
  logic [15:0] periodCycles, highCycles;
  integer      err_count, checks_done, cycles, seed, src, pol, pp, m, i;

  // Unselected pin carries the inverse wave, so a wrong pin shows the wrong edge
  timer_pulse_period_measure #(.WIDTH(8)) timer_pulse_period_measure_i (
    .clock(clock), .rst_n(rst_n), .ce(ce),
    .measuredInputPinA(inputPinSelect ? !pinLevel : pinLevel),
    .measuredInputPinB(inputPinSelect ? pinLevel : !pinLevel),
    .ringOscClock(ringOscClock), .countSourceSelect(countSourceSelect),
    .inputPinSelect(inputPinSelect), .modeWrite(modeWrite), .modeWriteData(modeWriteData),
    .prescalerWrite(prescalerWrite), .timerWrite(timerWrite), .writeData(writeData),
    .timerRead(timerRead), .modeReadData_q(modeReadData_q),
    .prescalerReadData_q(prescalerReadData_q), .timerReadData_q(timerReadData_q),
    .timerIrq_q(timerIrq_q), .edgeIrq_q(edgeIrq_q)
  );
  pulse_source_model pulse_source_model_i (
    .clock(clock), .enable(srcEnable), .periodCycles(periodCycles),
    .highCycles(highCycles), .pinLevel(pinLevel)
  );

  // Main clock; ring oscillator at a sixth of it keeps measured counts exact
  always #5 clock = ~clock;
  always #30 ringOscClock = ~ringOscClock;

  // Cut a hang short
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      err_count = err_count + 1;
      summarize;
    end
  end

  function integer divOf(input integer s);
    divOf = (s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 8 : 6;
  endfunction

  task tick;
    @(posedge clock);
    #1;
  endtask

  task check(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask

  task wrMode(input [7:0] d);
    modeWriteData = d;
    modeWrite = 1'b1;
    tick;
    modeWrite = 1'b0;
  endtask

  task wrReg(input isTimer, input [7:0] d);
    writeData = d;
    timerWrite = isTimer;
    prescalerWrite = !isTimer;
    tick;
    timerWrite = 1'b0;
    prescalerWrite = 1'b0;
  endtask

  // Nothing else is touched until the run status reads back as written
  task setRun(input [7:0] d);
    wrMode(d);
    i = 0;
    while (modeReadData_q[4] !== d[4] && i < 40) begin
      tick;
      i = i + 1;
    end
    check({7'h00, modeReadData_q[4]}, {7'h00, d[4]});
  endtask

  task waitIrq(input isEdge);
    i = 0;
    while ((isEdge ? edgeIrq_q : timerIrq_q) !== 1'b1 && i < 3000) begin
      tick;
      i = i + 1;
    end
    // A request that never comes is a mismatch, not a silent fall-through
    check({7'h00, i >= 3000}, 8'h00);
  endtask

  // Cycles between two timer requests; the first gap may be partial
  task gapCheck(input [7:0] expGap);
    waitIrq(1'b0);
    tick;
    waitIrq(1'b0);
    check(8'(i + 1), expGap);
  endtask

  task summarize;
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset, stopped load, interval counts, then period measurement
  initial begin
    seed = 32'h407f5b40;
    {clock, ringOscClock, inputPinSelect, srcEnable, timerRead} = 5'h00;
    {modeWrite, prescalerWrite, timerWrite, countSourceSelect} = 5'h00;
    {modeWriteData, writeData, periodCycles, highCycles} = 48'h0;
    rst_n = 1'b0;
    ce = 1'b1;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) tick;
    check(modeReadData_q, 8'h00);
    check(timerReadData_q, 8'hff);
    rst_n = 1'b1;
    t = 8'($random(seed));
    wrReg(1'b1, t);
    tick;
    tick;
    check(timerReadData_q, t);
    for (src = 0; src < 4; src = src + 1) begin
      countSourceSelect = 2'(src);
      p = 8'({$random(seed)} % 3);
      t = 8'(1 + {$random(seed)} % 5);
      wrReg(1'b0, p);
      wrReg(1'b1, t);
      check(prescalerReadData_q, p);
      setRun(8'h70);
      gapCheck(8'((p + 1) * (t + 1) * divOf(src)));
      if (src == 0) begin
        wrReg(1'b0, 8'h20);
        repeat (4) tick;
        wrReg(1'b1, t);
        gapCheck(8'(33 * (t + 1)));
      end
      setRun(8'h60);
      wrMode(8'h60);
      tick;
      tick;
      check(modeReadData_q, 8'h40);
      wrMode(8'h00);
      tick;
      tick;
      check(modeReadData_q, 8'h00);
    end
    for (src = 0; src < 8; src = src + 1) begin
      pol = src % 2;
      countSourceSelect = 2'(src / 2);
      inputPinSelect = pol[0] ^ src[1];
      p = 8'(2 + {$random(seed)} % 2);
      m = 8 + {$random(seed)} % 6;
      pp = (p + 1) * divOf(src / 2);
      periodCycles = 16'(m * pp);
      highCycles = 16'((pol[0] ? m - 4 : 4) * pp);
      srcEnable = 1'b1;
      wrReg(1'b0, p);
      wrReg(1'b1, 8'hff);
      wrMode({4'h0, pol[0], 3'h3});
      setRun({4'h7, pol[0], 3'h3});
      repeat (2 * pp + 2) tick;
      wrMode({4'h5, pol[0], 3'h3});
      waitIrq(1'b1);
      check({7'h00, pinLevel}, {7'h00, !pol[0]});
      tick;
      check({7'h00, modeReadData_q[5]}, 8'h01);
      // Reload request lands two prescaler periods after the edge request
      waitIrq(1'b0);
      check(8'(i), 8'(2 * pp - 1));
      repeat (pp + 5) tick;
      timerRead = 1'b1;
      tick;
      timerRead = 1'b0;
      waitIrq(1'b1);
      repeat (3 * pp + 4) tick;
      check(timerReadData_q, 8'(257 - m));
      setRun({4'h6, pol[0], 3'h3});
      srcEnable = 1'b0;
      // Let the source see the disable so the next wave starts from phase zero
      tick;
    end
    summarize;
  end
endmodule // testbench
`default_nettype wire
